/* dv/pmtc_monitor.sv */
// Port-level checker for the loop monitor and tick block
`timescale 1ns/1ps
module pmtc_monitor
#(
  parameter int WATCH_LIMIT = 64
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  // Unit status
  input wire logic CRYSTAL_TICK,
  input wire logic LOOP_STOP_IN_WAIT,
  input wire logic LIGHT_STOP_SELECT,
  input wire logic STOP_MODE,
  input wire logic LIGHT_STOP,
  input wire logic FREQ_ERR_LARGE,
  // Controls
  input wire logic LOOP_POWER,
  input wire logic LOOP_AUTO_LOCK,
  input wire logic WIDE_FILTER,
  input wire logic WATCHDOG_RUN,
  input wire logic BACKUP_CLOCK_ACTIVE,
  input wire logic MONITOR_RESET_REQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  int gap_ff;
  // Quiet cycles since last crystal pulse, saturates to stay small
  always_ff @(posedge CLK_SYS or negedge ARST_N)
    if (!ARST_N)
      gap_ff <= 0;
    else
      gap_ff <= CRYSTAL_TICK ? 0 : (gap_ff < 1000 ? gap_ff + 1 : gap_ff);
  // Handshake, watch and control relations
  AST_ACK_LAT: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack late");
  AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  AST_LOCK: assert property (LOOP_AUTO_LOCK |-> LOOP_POWER)
    else $error("lock without power");
  AST_PWR: assert property (BACKUP_CLOCK_ACTIVE |-> LOOP_POWER)
    else $error("loop off in backup");
  AST_WAIT: assert property (LOOP_STOP_IN_WAIT ##1 LOOP_STOP_IN_WAIT |-> WIDE_FILTER == FREQ_ERR_LARGE)
    else $error("auto not held");
  AST_WDOG: assert property (!LIGHT_STOP |-> WATCHDOG_RUN)
    else $error("watchdog stopped");
  AST_STOP: assert property (STOP_MODE && !LIGHT_STOP_SELECT ##1 STOP_MODE && !LIGHT_STOP_SELECT
    |-> !MONITOR_RESET_REQ && !$rose(BACKUP_CLOCK_ACTIVE))
    else $error("watch active in stop");
  AST_GAP: assert property (MONITOR_RESET_REQ || $rose(BACKUP_CLOCK_ACTIVE) |-> gap_ff >= WATCH_LIMIT)
    else $error("failure too early");
  AST_PULSE: assert property (MONITOR_RESET_REQ |=> !MONITOR_RESET_REQ)
    else $error("reset request too long");
endmodule // pmtc_monitor

bind pmtc_top pmtc_monitor #(.WATCH_LIMIT(WATCH_LIMIT)) pmtc_monitor_inst (.CLK_SYS, .ARST_N, .CYC_I,
  .STB_I, .ACK_O, .CRYSTAL_TICK, .LOOP_STOP_IN_WAIT, .LIGHT_STOP_SELECT, .STOP_MODE, .LIGHT_STOP,
  .FREQ_ERR_LARGE, .LOOP_POWER, .LOOP_AUTO_LOCK, .WIDE_FILTER, .WATCHDOG_RUN, .BACKUP_CLOCK_ACTIVE,
  .MONITOR_RESET_REQ);

/* dv/tb_pmtc_top.sv */
// Self-checking bench for the loop monitor and tick block
`timescale 1ns/1ps
module tb_pmtc_top;
  logic CLK_SYS = 1'h0, ARST_N = 1'h0, CYC_I = 1'h0, STB_I = 1'h0, WE_I = 1'h0, ten = 1'h1;
  logic [5:0] ADR_I = 6'h00;
  logic [3:0] SEL_I = 4'hF;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  logic CRYSTAL_TICK = 1'h0, LOOP_CLOCK_SELECT = 1'h0, LOOP_STOP_IN_WAIT = 1'h0, LIGHT_STOP_SELECT = 1'h0;
  logic STOP_MODE = 1'h0, LIGHT_STOP = 1'h0, SPECIAL_MODE = 1'h0, FREQ_ERR_LARGE = 1'h0, f;
  logic ACK_O, LOOP_POWER, LOOP_AUTO_LOCK, WIDE_FILTER, WATCHDOG_RUN, BACKUP_CLOCK_ACTIVE;
  logic MONITOR_RESET_REQ, TICK_IRQ;
  int error_cnt = 0, checks = 0;
  // Short watch window keeps failure scenarios brief
  pmtc_top #(.WATCH_LIMIT(8)) pmtc_top_inst (.CLK_SYS, .ARST_N, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I,
    .DAT_I, .DAT_O, .ACK_O, .CRYSTAL_TICK, .LOOP_CLOCK_SELECT, .LOOP_STOP_IN_WAIT, .LIGHT_STOP_SELECT,
    .STOP_MODE, .LIGHT_STOP, .SPECIAL_MODE, .FREQ_ERR_LARGE, .LOOP_POWER, .LOOP_AUTO_LOCK, .WIDE_FILTER,
    .WATCHDOG_RUN, .BACKUP_CLOCK_ACTIVE, .MONITOR_RESET_REQ, .TICK_IRQ);
  // Clock and a crystal pulse every cycle while enabled
  initial
    forever #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) CRYSTAL_TICK <= ten;
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e)
    begin
      error_cnt++;
      $display("mismatch %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  // Classic cycle; returns one idle cycle later with outputs settled
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int i;
    CYC_I <= 1'h1;
    STB_I <= 1'h1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge CLK_SYS);
      i++;
    end
    while (ACK_O !== 1'h1 && i < 20);
    q = DAT_O;
    CYC_I <= 1'h0;
    STB_I <= 1'h0;
    if (i == 20)
    begin
      chk(1'h0, 1'h1);
      results;
    end
    else
      @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // Watch window: k selects backup flag, else reset request
  task automatic wt(input logic k, input int n);
    f = 1'h0;
    repeat (n)
    begin
      @(posedge CLK_SYS);
      if ((k ? BACKUP_CLOCK_ACTIVE : MONITOR_RESET_REQ) === 1'h1)
        f = 1'h1;
    end
  endtask
  task automatic tick_run(input logic [7:0] v, input int n, input logic e);
    bus(1'h1, 6'h0C, 8'h80);
    bus(1'h1, 6'h1C, v);
    cyc(n);
    chk(TICK_IRQ, e);
  endtask
  task automatic sc_regs;
    rd(6'h18, 8'h00);
    rd(6'h1C, 8'h00);
    FREQ_ERR_LARGE <= 1'h1;
    bus(1'h1, 6'h18, 8'h76);
    rd(6'h18, 8'h76);
    chk(LOOP_AUTO_LOCK, 1'h1);
    chk(WIDE_FILTER, 1'h1);
    FREQ_ERR_LARGE <= 1'h0;
    bus(1'h1, 6'h18, 8'h77);
    chk(WIDE_FILTER, 1'h0);
    rd(6'h18, 8'h76);
    bus(1'h1, 6'h18, 8'h50);
    chk(WIDE_FILTER, 1'h1);
    chk(LOOP_AUTO_LOCK, 1'h0);
    LOOP_CLOCK_SELECT <= 1'h1;
    bus(1'h1, 6'h18, 8'h00);
    rd(6'h18, 8'h40);
    LOOP_CLOCK_SELECT <= 1'h0;
    LOOP_STOP_IN_WAIT <= 1'h1;
    bus(1'h1, 6'h18, 8'h40);
    rd(6'h18, 8'h60);
    LOOP_STOP_IN_WAIT <= 1'h0;
    LIGHT_STOP <= 1'h1;
    bus(1'h1, 6'h18, 8'h40);
    chk(WATCHDOG_RUN, 1'h0);
    bus(1'h1, 6'h18, 8'h42);
    chk(WATCHDOG_RUN, 1'h1);
    bus(1'h1, 6'h3C, 8'hFF);
    rd(6'h3C, 8'h00);
  endtask
  task automatic sc_tick;
    bus(1'h1, 6'h10, 8'h80);
    tick_run(8'h10, 1100, 1'h0);
    LIGHT_STOP <= 1'h0;
    tick_run(8'h10, 1016, 1'h0);
    cyc(16);
    chk(TICK_IRQ, 1'h1);
    tick_run(8'h11, 2040, 1'h0);
    cyc(16);
    chk(TICK_IRQ, 1'h1);
    rd(6'h0C, 8'h80);
    bus(1'h1, 6'h10, 8'h00);
    chk(TICK_IRQ, 1'h0);
    bus(1'h1, 6'h10, 8'h80);
    tick_run(8'h11, 1500, 1'h0);
    tick_run(8'h11, 1500, 1'h0);
    tick_run(8'h01, 3000, 1'h0);
  endtask
  task automatic sc_mon;
    bus(1'h1, 6'h18, 8'h80);
    ten <= 1'h0;
    wt(1'h0, 20);
    chk(f, 1'h1);
    ten <= 1'h1;
    STOP_MODE <= 1'h1;
    cyc(2);
    ten <= 1'h0;
    wt(1'h0, 30);
    chk(f, 1'h0);
    ten <= 1'h1;
    STOP_MODE <= 1'h0;
    SPECIAL_MODE <= 1'h1;
    bus(1'h1, 6'h18, 8'h81);
    ten <= 1'h0;
    wt(1'h1, 20);
    chk(f, 1'h1);
    chk(LOOP_POWER, 1'h1);
    bus(1'h1, 6'h18, 8'h00);
    rd(6'h18, 8'h81);
    rd(6'h0C, 8'h02);
    ten <= 1'h1;
    cyc(4);
    chk(LOOP_POWER, 1'h0);
  endtask
  // Reset for three cycles, then the scenarios
  initial
  begin
    cyc(3);
    ARST_N <= 1'h1;
    cyc(1);
    sc_regs;
    sc_tick;
    sc_mon;
    results;
  end
endmodule // tb_pmtc_top

/* src/pmtc_pkg.sv */
// Package for the loop monitor and periodic tick control block
package pmtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_TICK_STATUS = 4'h3;
  localparam logic [3:0] IDX_TICK_IRQ_EN = 4'h4;
  localparam logic [3:0] IDX_LOOP_CTRL = 4'h6;
  localparam logic [3:0] IDX_TICK_CTRL = 4'h7;

  // Reset values
  localparam logic [7:0] LOOP_CTRL_RST = 8'h00;
  localparam logic [7:0] TICK_CTRL_RST = 8'h00;

  // Status and enable bit positions
  localparam int TICK_FLAG_BIT = 7;
  localparam int BACKUP_ACTIVE_BIT = 1;
  localparam int TICK_IRQ_EN_BIT = 7;

  // Tick prescale field position and base shift
  localparam int PRESCALE_LSB = 4;
  localparam int PRESCALE_BASE = 9;

  // Clock failure watch window in system clocks
  localparam int WATCH_LIMIT_DEF = 64;

  // Loop control register layout, bit 7 first
  typedef struct packed {
    logic clock_fail_watch_enable;
    logic loop_power_on;
    logic auto_bandwidth;
    logic wide_loop_filter;
    logic reserved3;
    logic tick_run_in_light_stop;
    logic watchdog_run_in_light_stop;
    logic backup_clock_enable;
  } pmtc_loop_ctrl_t;

  // Tick control register layout
  typedef struct packed {
    logic reserved7;
    logic [2:0] prescale;
    logic [3:0] modulus;
  } pmtc_tick_ctrl_t;

  // Terminal count of crystal ticks for a tick control setting
  function automatic logic [20:0] tick_period(input pmtc_tick_ctrl_t t);
    logic [20:0] m;
    m = {17'h00000, t.modulus} + 21'h000001;
    return (m << (PRESCALE_BASE + int'(t.prescale))) - 21'h000001;
  endfunction

endpackage

/* src/pmtc_top.sv */
// Loop monitor and periodic tick control with classic Wishbone slave
`timescale 1ns/1ps
module pmtc_top
  import pmtc_pkg::*;
#(
  parameter int WATCH_LIMIT = WATCH_LIMIT_DEF
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [5:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Unit status inputs
  input wire logic CRYSTAL_TICK,
  input wire logic LOOP_CLOCK_SELECT,
  input wire logic LOOP_STOP_IN_WAIT,
  input wire logic LIGHT_STOP_SELECT,
  input wire logic STOP_MODE,
  input wire logic LIGHT_STOP,
  input wire logic SPECIAL_MODE,
  input wire logic FREQ_ERR_LARGE,
  // Control outputs
  output logic LOOP_POWER,
  output logic LOOP_AUTO_LOCK,
  output logic WIDE_FILTER,
  output logic WATCHDOG_RUN,
  output logic BACKUP_CLOCK_ACTIVE,
  output logic MONITOR_RESET_REQ,
  output logic TICK_IRQ
);

  pmtc_loop_ctrl_t loop_ff;
  pmtc_tick_ctrl_t tick_ctrl_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic tick_flag_ff;
  logic tick_irq_en_ff;
  logic backup_active_ff;
  logic backup_written_ff;
  logic mon_reset_ff;
  logic [20:0] tick_cnt_ff;
  logic [15:0] watch_cnt_ff;
  logic [20:0] nxt_tick_cnt;
  logic req;
  logic wr;
  logic [3:0] idx;
  logic [7:0] wdat;
  logic wr_loop;
  logic wr_tick;
  logic tick_done;
  logic tick_frozen;
  logic watch_active;
  logic fail_detect;

  // Bus decode; a write lands on the edge where ack is seen high
  assign req = CYC_I & STB_I;
  assign idx = ADR_I[5:2];
  assign wdat = DAT_I[7:0];
  assign wr = req & ack_ff & WE_I & SEL_I[0];
  assign wr_loop = wr & (idx == IDX_LOOP_CTRL);
  assign wr_tick = wr & (idx == IDX_TICK_CTRL);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // Read data captured with the ack; unmapped indices read zero
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_ff <= 32'h00000000;
    else if (req & ~ack_ff)
    begin
      case (idx)
        IDX_LOOP_CTRL: rdata_ff <= {24'h000000, loop_ff};
        IDX_TICK_CTRL: rdata_ff <= {24'h000000, tick_ctrl_ff};
        IDX_TICK_STATUS:
          rdata_ff <= {24'h000000, tick_flag_ff, 5'h00, backup_active_ff, 1'b0};
        IDX_TICK_IRQ_EN: rdata_ff <= {24'h000000, tick_irq_en_ff, 7'h00};
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // Watch enable; frozen while backup clock runs
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      loop_ff.clock_fail_watch_enable <= LOOP_CTRL_RST[7];
    else if (wr_loop & ~backup_active_ff)
      loop_ff.clock_fail_watch_enable <= wdat[7];
  end

  // Loop power; changing it under a selected loop clock would glitch the system
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      loop_ff.loop_power_on <= LOOP_CTRL_RST[6];
    else if (wr_loop & ~LOOP_CLOCK_SELECT)
      loop_ff.loop_power_on <= wdat[6];
  end

  // Auto bandwidth, pinned high by loop stop in wait
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      loop_ff.auto_bandwidth <= LOOP_CTRL_RST[5];
    else if (LOOP_STOP_IN_WAIT)
      loop_ff.auto_bandwidth <= 1'b1;
    else if (wr_loop)
      loop_ff.auto_bandwidth <= wdat[5];
  end

  // Freely writable bits; bit 3 stays reserved and reads zero
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      loop_ff.wide_loop_filter <= LOOP_CTRL_RST[4];
      loop_ff.reserved3 <= 1'b0;
      loop_ff.tick_run_in_light_stop <= LOOP_CTRL_RST[2];
      loop_ff.watchdog_run_in_light_stop <= LOOP_CTRL_RST[1];
    end
    else if (wr_loop)
    begin
      loop_ff.wide_loop_filter <= wdat[4];
      loop_ff.reserved3 <= 1'b0;
      loop_ff.tick_run_in_light_stop <= wdat[2];
      loop_ff.watchdog_run_in_light_stop <= wdat[1];
    end
  end

  // Backup enable: write once outside special modes, no clear while active
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      loop_ff.backup_clock_enable <= LOOP_CTRL_RST[0];
      backup_written_ff <= 1'b0;
    end
    else if (wr_loop & (SPECIAL_MODE | ~backup_written_ff))
    begin
      backup_written_ff <= 1'b1;
      if (wdat[0] | ~backup_active_ff)
        loop_ff.backup_clock_enable <= wdat[0];
    end
  end

  // Clock failure watch: no crystal tick within the window means failure
  assign watch_active = loop_ff.clock_fail_watch_enable & ~(STOP_MODE & ~LIGHT_STOP_SELECT);
  assign fail_detect = watch_active & (watch_cnt_ff == 16'(WATCH_LIMIT - 1)) & ~CRYSTAL_TICK;

  // Window counter, restarted by every crystal tick
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      watch_cnt_ff <= 16'h0000;
    else if (~watch_active | CRYSTAL_TICK | fail_detect)
      watch_cnt_ff <= 16'h0000;
    else
      watch_cnt_ff <= watch_cnt_ff + 16'h0001;
  end

  // Failure response; backup mode ends when the crystal returns
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      backup_active_ff <= 1'b0;
      mon_reset_ff <= 1'b0;
    end
    else
    begin
      mon_reset_ff <= fail_detect & ~loop_ff.backup_clock_enable;
      if (fail_detect & loop_ff.backup_clock_enable)
        backup_active_ff <= 1'b1;
      else if (CRYSTAL_TICK)
        backup_active_ff <= 1'b0;
    end
  end

  // Tick counter on crystal ticks; frozen, not cleared, in light stop unless tick_run_in_light_stop is set
  assign tick_frozen = LIGHT_STOP & ~loop_ff.tick_run_in_light_stop;
  assign tick_done = CRYSTAL_TICK & ~tick_frozen & (tick_ctrl_ff.prescale != 3'h0) &
                     (tick_cnt_ff == tick_period(tick_ctrl_ff));

  // Next tick count
  always_comb
  begin
    nxt_tick_cnt = tick_cnt_ff;
    if (wr_tick | (tick_ctrl_ff.prescale == 3'h0) | tick_done)
      nxt_tick_cnt = 21'h000000;
    else if (CRYSTAL_TICK & ~tick_frozen)
      nxt_tick_cnt = tick_cnt_ff + 21'h000001;
  end

  // Tick counter register
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      tick_cnt_ff <= 21'h000000;
    else
      tick_cnt_ff <= nxt_tick_cnt;
  end

  // Tick control register, writable at any time
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      tick_ctrl_ff <= TICK_CTRL_RST;
    else if (wr_tick)
      tick_ctrl_ff <= {1'b0, wdat[6:0]};
  end

  // Tick flag, write one to clear; a new tick beats the clear
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      tick_flag_ff <= 1'b0;
    else if (tick_done)
      tick_flag_ff <= 1'b1;
    else if (wr & (idx == IDX_TICK_STATUS) & wdat[TICK_FLAG_BIT])
      tick_flag_ff <= 1'b0;
  end

  // Tick interrupt enable
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      tick_irq_en_ff <= 1'b0;
    else if (wr & (idx == IDX_TICK_IRQ_EN))
      tick_irq_en_ff <= wdat[TICK_IRQ_EN_BIT];
  end

  // Outputs to the rest of the unit
  assign DAT_O = rdata_ff;
  assign ACK_O = ack_ff;
  assign LOOP_POWER = loop_ff.loop_power_on | backup_active_ff;
  assign LOOP_AUTO_LOCK = LOOP_POWER & loop_ff.auto_bandwidth;
  assign WIDE_FILTER = loop_ff.auto_bandwidth ? FREQ_ERR_LARGE : loop_ff.wide_loop_filter;
  assign WATCHDOG_RUN = ~(LIGHT_STOP & ~loop_ff.watchdog_run_in_light_stop);
  assign BACKUP_CLOCK_ACTIVE = backup_active_ff;
  assign MONITOR_RESET_REQ = mon_reset_ff;
  assign TICK_IRQ = tick_flag_ff & tick_irq_en_ff;

endmodule // pmtc_top
